/* core/eeprom_pkg.sv */
/*
 * Shared constants and types for the two-wire serial EEPROM slave:
 * array geometry, control codes, lock command bytes and write timing.
 * Assumes a 200 MHz system clock sampling the bus pins.
 */
package eeprom_pkg;

	// System clock and program cycle timing
	localparam int CLK_PERIOD_NS          = 5;
	localparam int PROGRAM_CYCLE_TIME_MS  = 5;
	localparam int PROGRAM_CYCLE_CNT      =
		(PROGRAM_CYCLE_TIME_MS * 1000000) / CLK_PERIOD_NS;

	// Array geometry
	localparam int ADDR_W                 = 8;
	localparam int DATA_W                 = 8;
	localparam int OFFSET_W               = 4;
	localparam int PAGE_W                 = ADDR_W - OFFSET_W;
	localparam int PAGE_BYTES             = 16;
	localparam int MEM_DEPTH              = 256;

	// Bits per serial word, counted before the acknowledge clock
	localparam logic [3:0] BITS_PER_WORD  = 4'h8;

	// Control codes in the upper four bits of the device address byte
	localparam logic [3:0] CTRL_ARRAY     = 4'ha;
	localparam logic [3:0] CTRL_LOCK      = 4'h6;

	// Reversible lock command bytes and their strap patterns
	localparam logic [7:0] SET_REV_BYTE   = 8'h62;
	localparam logic [7:0] CLR_REV_BYTE   = 8'h66;
	localparam logic [1:0] SET_REV_STRAPS = 2'h0;
	localparam logic [1:0] CLR_REV_STRAPS = 2'h1;

	// Address bit that separates the software-protected lower half
	localparam int HALF_BIT               = 7;

	// Reset values
	localparam logic LOCK_RESET           = 1'h0;
	localparam logic [7:0] ADDR_RESET     = 8'h00;

	// Kind of command taken with the device address byte
	typedef enum {
		OP_NONE,
		OP_ARRAY,
		OP_SET_PERM,
		OP_SET_REV,
		OP_CLR_REV
	} op_t;

	// Serial protocol states
	typedef enum {
		ST_IDLE,
		ST_DEV,
		ST_WORD,
		ST_DATA,
		ST_ACK,
		ST_IGNORE
	} state_t;

endpackage

/* core/pin_sync.sv */
/*
 * Two flip-flop synchroniser for a group of asynchronous pin inputs.
 * Assumes each bit is an independent level; no word coherence.
 */
`timescale 1ns/1ps

module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk, // System clock
	input  wire logic [W-1:0] d,   // Asynchronous inputs
	output logic      [W-1:0] q    // Synchronised levels
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		meta_q <= d;
		q      <= meta_q;
	end

endmodule

/* core/busy_timer.sv */
/*
 * Self-timed program cycle counter, running on the free system clock.
 * Assumes start is a one-cycle pulse; a start while busy restarts it.
 */
`timescale 1ns/1ps

module busy_timer #(
	parameter int CYCLES = 1000000
) (
	input  wire logic clk,   // System clock
	input  wire logic rst,   // Synchronous reset, active high
	input  wire logic start, // Pulse: begin a program cycle
	output logic      busy   // High for CYCLES clocks after start
);

	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] cnt_q;

	// Load on start, count down while busy, drop busy at zero
	always_ff @(posedge clk) begin
		if (rst) begin
			busy  <= 1'b0;
			cnt_q <= '0;
		end else if (start) begin
			busy  <= 1'b1;
			cnt_q <= CW'(CYCLES - 1);
		end else if (busy) begin
			if (cnt_q == '0) begin
				busy <= 1'b0;
			end else begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

endmodule

/* core/twowire_eeprom.sv */
/*
 * Two-wire serial EEPROM slave: 256 x 8 array, byte and page writes,
 * self-timed program cycle, hardware pin and two software write locks.
 * Assumes SCL, SDA and the straps are asynchronous pins sampled by a
 * free-running 200 MHz clock; SDA is open drain and resolved outside.
 */
`timescale 1ns/1ps

// Behaviour
// RULE1: Array is 16 pages of 16 bytes; page from upper address bits.
// RULE2: Each random write carries one 8-bit word address.
// RULE3: SDA change while SCL high means start or stop, not data.
// RULE4: SDA falling while SCL high is a start; master starts commands.
// RULE5: SDA rising while SCL high is a stop; returns to standby.
// RULE6: Words are 8 bits; device pulls SDA low on the ninth clock.
// RULE7: Standby at power-up and after stop once programming ends.
// RULE8: Master recovers by clocking up to nine times then a start.
// RULE9: Control code 1010 selects the array, 0110 the lock registers.
// RULE10: Address bits 3..1 must match straps, else no ack, standby.
// RULE11: Address bit 0 high is read, low is write.
// RULE12: With permanent lock set, 0110 address bytes get no ack.
// RULE13: Byte write: address, data, stop, then inputs ignored.
// RULE14: Protected writes are acked, not stored, but still busy.
// RULE15: Page write takes up to sixteen data bytes, each acked.
// RULE16: Only the low four address bits advance; wrap inside page.
// RULE17: During programming the device address gets no ack.
// RULE18: Software locks guard 00H to 7FH; the pin guards everything.
// RULE19: 0110 write with matching straps sets the permanent lock.
// RULE20: Byte 01100010 with straps 0,0,high voltage sets reversible.
// RULE21: Byte 01100110 with straps 0,1,high voltage clears reversible.
// RULE22: Protect pin high guards all and blocks lock programming.
// RULE23: Protect pin low lets the software locks decide.
// RULE24: Pin low and a lock set: only 80H to FFH change.
// RULE25: Reversible lock query acked when clear, not when set.
// RULE26: High voltage on strap zero arrives as its own input.
// RULE27: Program cycle length is a parameter in system clocks.
module twowire_eeprom
	import eeprom_pkg::*;
#(
	parameter int PROGRAM_CYCLES = eeprom_pkg::PROGRAM_CYCLE_CNT
) (
	input  wire logic                         clk,    // 200 MHz clock
	input  wire logic                         rst,    // Sync reset
	input  wire logic                         scl,    // Bus clock pin
	input  wire logic                         sda_i,  // Resolved SDA
	output logic                              sda_o,  // SDA drive level
	output logic                              sda_oe, // SDA pulled low
	input  wire logic                         chip_select_strap_two,
	input  wire logic                         chip_select_strap_one,
	input  wire logic                         chip_select_strap_zero,
	input  wire logic                         high_voltage_level,
	input  wire logic                         write_protect, // Pin
	input  wire logic [eeprom_pkg::ADDR_W-1:0] peek_addr, // Array probe
	output logic      [eeprom_pkg::DATA_W-1:0] peek_data, // Probe data
	output logic                              busy,   // Programming
	output logic                              standby, // Idle
	output logic                              permanent_lock_flag,
	output logic                              reversible_lock_flag
);
	import eeprom_pkg::*;

	// Synchronised pins
	logic       scl_s;
	logic       sda_s;
	logic [2:0] strap_s;
	logic       hv_s;
	logic       wp_s;

	// Protocol state
	state_t            st_q;
	state_t            after_q;
	op_t               op_q;
	logic [3:0]        bitcnt_q;
	logic [DATA_W-1:0] shift_q;
	logic              scl_p_q;
	logic              sda_p_q;
	logic              got_data_q;

	// Write path state
	logic [ADDR_W-1:0]   addr_q;
	logic [DATA_W-1:0]   page_buf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] mask_q;
	logic [DATA_W-1:0]   mem [MEM_DEPTH];

	// Combinational decode
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic byte_done;
	logic ack_ok;
	op_t  dev_op;
	logic commit;
	logic timer_busy;
	logic lower_prot;
	logic array_prot;

	// Every bus pin and strap passes two flops before use
	pin_sync #(
		.W (7)
	) u_pin_sync (
		.clk (clk),
		.d   ({scl, sda_i, chip_select_strap_two, chip_select_strap_one,
		       chip_select_strap_zero, high_voltage_level,
		       write_protect}),
		.q   ({scl_s, sda_s, strap_s, hv_s, wp_s})
	);

	// Previous sampled levels for edge detection
	always_ff @(posedge clk) begin
		if (rst) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// Edges of SCL, and SDA edges while SCL stays high
	assign scl_rise  = scl_s & ~scl_p_q;
	assign scl_fall  = ~scl_s & scl_p_q;
	assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s; // RULE3 RULE4
	assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s; // RULE3 RULE5
	assign byte_done = scl_fall && (bitcnt_q == BITS_PER_WORD)
		&& (st_q == ST_DEV || st_q == ST_WORD || st_q == ST_DATA);

	// Classify the device address byte
	always_comb begin
		dev_op = OP_NONE;
		ack_ok = 1'b0;
		if (shift_q[7:4] == CTRL_ARRAY) begin // RULE9
			if (shift_q[3:1] == strap_s) begin // RULE10
				dev_op = shift_q[0] ? OP_NONE : OP_ARRAY; // RULE11
				ack_ok = 1'b1;
			end
		end else if (shift_q[7:4] == CTRL_LOCK && !permanent_lock_flag) begin
			// RULE12 RULE26
			if (hv_s && shift_q[0]) begin
				ack_ok = !reversible_lock_flag; // RULE25
			end else if (hv_s && shift_q == SET_REV_BYTE
				&& strap_s[2:1] == SET_REV_STRAPS) begin
				dev_op = OP_SET_REV; // RULE20
				ack_ok = !reversible_lock_flag;
			end else if (hv_s && shift_q == CLR_REV_BYTE
				&& strap_s[2:1] == CLR_REV_STRAPS) begin
				dev_op = OP_CLR_REV; // RULE21
				ack_ok = 1'b1;
			end else if (!hv_s && shift_q[3:1] == strap_s) begin
				dev_op = shift_q[0] ? OP_NONE : OP_SET_PERM; // RULE19
				ack_ok = 1'b1;
			end
		end
		if (timer_busy) begin
			ack_ok = 1'b0; // RULE13 RULE17
		end
	end

	// Serial protocol sequencer; a start aborts any transfer
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q     <= ST_IDLE; // RULE7
			after_q  <= ST_IDLE;
			bitcnt_q <= 4'h0;
			shift_q  <= 8'h00;
			sda_oe   <= 1'b0;
		end else if (start_det) begin
			st_q     <= ST_DEV; // RULE4 RULE8
			bitcnt_q <= 4'h0;
			sda_oe   <= 1'b0;
		end else if (stop_det) begin
			st_q   <= ST_IDLE; // RULE5
			sda_oe <= 1'b0;
		end else begin
			case (st_q)
				ST_DEV, ST_WORD, ST_DATA: begin
					if (scl_rise && bitcnt_q != BITS_PER_WORD) begin
						shift_q  <= {shift_q[6:0], sda_s}; // RULE6
						bitcnt_q <= bitcnt_q + 4'h1;
					end else if (byte_done) begin
						if (st_q != ST_DEV || ack_ok) begin
							sda_oe <= 1'b1; // RULE6 RULE15
							st_q   <= ST_ACK;
						end else begin
							st_q <= ST_IGNORE; // RULE10
						end
						if (st_q == ST_DEV) begin
							after_q <= shift_q[0] ? ST_IGNORE : ST_WORD;
						end else begin
							after_q <= ST_DATA; // RULE2 RULE15
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						sda_oe   <= 1'b0;
						st_q     <= after_q;
						bitcnt_q <= 4'h0;
					end
				end
				ST_IGNORE: begin
					sda_oe <= 1'b0;
				end
				default: begin
					sda_oe <= 1'b0;
				end
			endcase
		end
	end

	// SDA is only ever pulled low
	always_ff @(posedge clk) begin
		if (rst) begin
			sda_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
		end
	end

	// Command kind and whether a data byte has arrived since start
	always_ff @(posedge clk) begin
		if (rst) begin
			op_q       <= OP_NONE;
			got_data_q <= 1'b0;
		end else if (start_det || stop_det) begin
			got_data_q <= 1'b0;
			if (start_det) begin
				op_q <= OP_NONE;
			end
		end else if (byte_done && st_q == ST_DEV) begin
			op_q <= ack_ok ? dev_op : OP_NONE;
		end else if (byte_done && st_q == ST_DATA) begin
			got_data_q <= 1'b1;
		end
	end

	// Word address capture and in-page advance
	always_ff @(posedge clk) begin
		if (rst) begin
			addr_q <= ADDR_RESET;
		end else if (byte_done && st_q == ST_WORD) begin
			addr_q <= shift_q; // RULE2
		end else if (byte_done && st_q == ST_DATA) begin
			// RULE16
			addr_q[OFFSET_W-1:0] <= addr_q[OFFSET_W-1:0] + 4'h1;
		end
	end

	// Page buffer; a wrapped page overwrites earlier bytes
	always_ff @(posedge clk) begin
		if (rst || start_det) begin
			mask_q <= '0;
		end else if (byte_done && st_q == ST_DATA) begin
			page_buf[addr_q[OFFSET_W-1:0]] <= shift_q; // RULE1 RULE16
			mask_q[addr_q[OFFSET_W-1:0]]   <= 1'b1;
		end
	end

	// A stop after a data byte starts the program cycle
	assign commit = stop_det && got_data_q && op_q != OP_NONE
		&& !timer_busy; // RULE13

	// Protection of the selected page
	assign lower_prot = (permanent_lock_flag | reversible_lock_flag)
		& ~addr_q[HALF_BIT]; // RULE18 RULE23 RULE24
	assign array_prot = wp_s | lower_prot; // RULE22

	// Program cycle timer on the free system clock
	busy_timer #(
		.CYCLES (PROGRAM_CYCLES) // RULE27
	) u_busy_timer (
		.clk   (clk),
		.rst   (rst),
		.start (commit), // RULE14
		.busy  (timer_busy)
	);

	// Array programming of the buffered bytes of one page
	always_ff @(posedge clk) begin
		if (commit && op_q == OP_ARRAY && !array_prot) begin // RULE14
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (mask_q[i]) begin
					mem[{addr_q[ADDR_W-1:OFFSET_W], OFFSET_W'(i)}]
						<= page_buf[i]; // RULE1
				end
			end
		end
	end

	// Lock registers; the protect pin blocks programming them
	always_ff @(posedge clk) begin
		if (rst) begin
			permanent_lock_flag  <= LOCK_RESET;
			reversible_lock_flag <= LOCK_RESET;
		end else if (commit && !wp_s) begin // RULE22
			case (op_q)
				OP_SET_PERM: permanent_lock_flag  <= 1'b1; // RULE19
				OP_SET_REV:  reversible_lock_flag <= 1'b1; // RULE20
				OP_CLR_REV:  reversible_lock_flag <= 1'b0; // RULE21
				default:     permanent_lock_flag  <= permanent_lock_flag;
			endcase
		end
	end

	// Status outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			busy    <= 1'b0;
			standby <= 1'b1;
		end else begin
			busy    <= timer_busy | commit;
			standby <= (st_q == ST_IDLE || st_q == ST_IGNORE)
				&& !timer_busy && !commit; // RULE7
		end
	end

	// Array probe for checking the stored contents
	always_ff @(posedge clk) begin
		if (rst) begin
			peek_data <= 8'h00;
		end else begin
			peek_data <= mem[peek_addr];
		end
	end

endmodule

/* tb/eeprom_chk.sv */
/*
 * Checker for the two-wire EEPROM slave, watching its top ports.
 * Assumes one clock domain and SCL held low at least 6 clocks.
 */
`timescale 1ns/1ps

module eeprom_chk #(
	parameter int PROGRAM_CYCLES = 50
) (
	input wire logic clk,                  // System clock
	input wire logic rst,                  // Sync reset
	input wire logic scl,                  // Bus clock pin
	input wire logic sda_oe,               // Ack drive
	input wire logic busy,                 // Programming
	input wire logic standby,              // Idle
	input wire logic write_protect,        // Protect pin
	input wire logic high_voltage_level,   // Strap zero qualifier
	input wire logic permanent_lock_flag,  // Permanent lock
	input wire logic reversible_lock_flag  // Reversible lock
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [31:0] run_q;
	// Length of the running program cycle
	always_ff @(posedge clk) begin
		if (rst || !busy) begin
			run_q <= 32'h0;
		end else begin
			run_q <= run_q + 32'h1;
		end
	end
	sequence busy_run;
		busy[*8];
	endsequence
	sequence idle_back;
		##[0:2] standby;
	endsequence
	a_reset_idle: assert property (disable iff (1'b0) rst |=>
		!busy && standby && !sda_oe && !permanent_lock_flag)
		else $error("state after reset not idle");
	a_busy_hold: assert property ($rose(busy) |-> busy_run)
		else $error("program cycle cut short");
	a_busy_len: assert property ($fell(busy) |->
		run_q >= PROGRAM_CYCLES && run_q <= PROGRAM_CYCLES + 2)
		else $error("program cycle length wrong");
	a_busy_quiet: assert property (busy |-> !sda_oe)
		else $error("acknowledge while programming");
	a_ack_low: assert property ($rose(sda_oe) |-> !scl)
		else $error("ack drive began with SCL high");
	a_ack_held: assert property ($fell(sda_oe) |-> !scl)
		else $error("ack drive ended with SCL high");
	a_standby_back: assert property ($fell(busy) |-> idle_back)
		else $error("no standby after program cycle");
	a_perm_keep: assert property (permanent_lock_flag |=>
		permanent_lock_flag)
		else $error("permanent lock cleared");
	a_lock_wp: assert property ($rose(permanent_lock_flag) ||
		$rose(reversible_lock_flag) |-> !write_protect)
		else $error("lock set while pin protects");
	a_rev_hv: assert property ($changed(reversible_lock_flag) |->
		high_voltage_level && busy)
		else $error("reversible lock moved without qualifier");
endmodule

/* tb/bus_master.sv */
/*
 * Two-wire bus master model: start, stop and byte transfers.
 * Assumes SDA is open drain and resolved by the bench.
 */
`timescale 1ns/1ps

module bus_master (
	input  wire logic clk,  // System clock
	input  wire logic line, // Resolved SDA level
	output logic      scl,  // Bus clock, idles high
	output logic      sda   // High means released
);
	// Bus idles released
	initial begin
		scl <= 1'h1;
		sda <= 1'h1;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One bit; data moves only while SCL is low
	task automatic bitx(input logic b, output logic r);
		sda <= b;
		tk(3);
		scl <= 1'h1;
		tk(3);
		r = line;
		tk(3);
		scl <= 1'h0;
		tk(3);
	endtask
	// SDA falls with SCL high
	task automatic start();
		sda <= 1'h1;
		tk(3);
		scl <= 1'h1;
		tk(3);
		sda <= 1'h0;
		tk(3);
		scl <= 1'h0;
		tk(3);
	endtask
	// SDA rises with SCL high, then the bus rests
	task automatic stop();
		sda <= 1'h0;
		tk(3);
		scl <= 1'h1;
		tk(3);
		sda <= 1'h1;
		tk(3);
	endtask
	// Recovery after a cut transfer: nine clocks with SDA released
	task automatic recover();
		logic r;
		repeat (9) bitx(1'h1, r);
	endtask
	// Eight bits MSB first, then the ninth clock for the ack
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
		end
		bitx(1'h1, r);
		ack = !r;
	endtask
endmodule

/* tb/test_twowire_eeprom.sv */
/*
 * Bench for the two-wire EEPROM slave: writes, page wrap, polling,
 * locks and protect pin, driven through the bus master model.
 * Assumes the package, design and model are compiled first.
 */
`timescale 1ns/1ps

module test_twowire_eeprom;
	import eeprom_pkg::*;
	localparam int PC = 300; // Shortened program cycle
	logic       clk, rst, scl, m_sda, line, s2, s1, s0, hv, wp;
	logic       sda_oe, busy, standby, pflag, rflag, ok;
	logic [7:0] pa, pd;
	int         mismatches, cmp_count, cyc, k;
	// Open-drain wire with pull-up
	assign line = m_sda & !sda_oe;
	twowire_eeprom #(.PROGRAM_CYCLES(PC)) twowire_eeprom_inst (
		.clk(clk), .rst(rst), .scl(scl), .sda_i(line), .sda_o(),
		.sda_oe(sda_oe), .chip_select_strap_two(s2),
		.chip_select_strap_one(s1), .chip_select_strap_zero(s0),
		.high_voltage_level(hv), .write_protect(wp), .peek_addr(pa),
		.peek_data(pd), .busy(busy), .standby(standby),
		.permanent_lock_flag(pflag), .reversible_lock_flag(rflag));
	bus_master bus_master_inst (.clk(clk), .line(line), .scl(scl),
		.sda(m_sda));
	// Clock
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			mismatches++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] s, e);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	// Device byte, word address, n data bytes from d0, stop
	task automatic wr(input logic [7:0] dev, a, d0, input int n);
		logic g;
		bus_master_inst.start();
		bus_master_inst.put(dev, ok);
		for (int i = 0; i <= n && ok; i++) begin
			bus_master_inst.put(i == 0 ? a : d0 + 8'(i - 1), g);
			ok = g;
		end
		bus_master_inst.stop();
		repeat (4) @(posedge clk);
	endtask
	// Wait out the program cycle
	task automatic settle();
		int t;
		t = 0;
		while (busy !== 1'h0 && t < 2000) begin
			@(posedge clk);
			t++;
		end
		chk("busy", busy, 8'h0);
	endtask
	task automatic pk(input logic [7:0] a, e);
		pa <= a;
		repeat (3) @(posedge clk);
		chk("array", pd, e);
	endtask
	initial begin
		{rst, s2, s1, s0, hv, wp, pa} = {6'h20, 8'h00};
		{mismatches, cmp_count, cyc} = '0;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		repeat (4) @(posedge clk);
		chk("idle", {busy, standby, pflag, rflag}, 8'h4);
		wr(8'ha2, 8'h0, 8'h0, -1);
		chk("ack", ok, 8'h0);
		wr(8'hb0, 8'h0, 8'h0, -1);
		chk("ack", ok, 8'h0);
		// Byte write, then polls during and after programming
		wr(8'ha0, 8'h10, 8'h3c, 1);
		chk("ack", ok, 8'h1);
		chk("standby", standby, 8'h0);
		wr(8'ha0, 8'h0, 8'h0, -1);
		chk("poll", ok, 8'h0);
		settle();
		pk(8'h10, 8'h3c);
		wr(8'ha1, 8'h0, 8'h0, -1);
		chk("poll", ok, 8'h1);
		// Eighteen bytes from offset 14 wrap inside the page
		wr(8'ha0, 8'h9e, 8'h40, 18);
		chk("ack", ok, 8'h1);
		settle();
		for (int o = 0; o < 16; o++) begin
			k = (o + 2) % 16;
			k = k < 2 ? k + 16 : k;
			pk(8'h90 + 8'(o), 8'h40 + 8'(k));
		end
		// Reversible lock guards the lower half only
		hv <= 1'h1;
		wr(8'h62, 8'h0, 8'h0, 1);
		settle();
		chk("rlock", rflag, 8'h1);
		wr(8'h63, 8'h0, 8'h0, -1);
		chk("query", ok, 8'h0);
		hv <= 1'h0;
		wr(8'ha0, 8'h10, 8'h77, 1);
		chk("ack", ok, 8'h1);
		settle();
		pk(8'h10, 8'h3c);
		wr(8'ha0, 8'h90, 8'h77, 1);
		settle();
		pk(8'h90, 8'h77);
		{s1, hv} <= 2'h3;
		wr(8'h66, 8'h0, 8'h0, 1);
		settle();
		chk("rlock", rflag, 8'h0);
		// Protect pin guards all and blocks lock programming
		{s1, wp} <= 2'h1;
		wr(8'h62, 8'h0, 8'h0, 1);
		settle();
		chk("rlock", rflag, 8'h0);
		hv <= 1'h0;
		wr(8'ha0, 8'h90, 8'h11, 1);
		chk("ack", ok, 8'h1);
		chk("busy", busy, 8'h1);
		settle();
		pk(8'h90, 8'h77);
		wp <= 1'h0;
		wr(8'ha0, 8'h10, 8'h55, 1);
		settle();
		pk(8'h10, 8'h55);
		// Cut a transfer, recover the bus, then write normally
		bus_master_inst.start();
		bus_master_inst.put(8'ha0, ok);
		bus_master_inst.recover();
		wr(8'ha0, 8'h20, 8'h66, 1);
		chk("ack", ok, 8'h1);
		settle();
		pk(8'h20, 8'h66);
		// Permanent lock
		wr(8'h60, 8'h0, 8'h0, 1);
		chk("ack", ok, 8'h1);
		settle();
		chk("plock", pflag, 8'h1);
		wr(8'h60, 8'h0, 8'h0, -1);
		chk("ack", ok, 8'h0);
		wr(8'ha0, 8'h10, 8'h99, 1);
		settle();
		pk(8'h10, 8'h55);
		wrap_up();
	end
endmodule

bind twowire_eeprom eeprom_chk #(.PROGRAM_CYCLES(PROGRAM_CYCLES))
	eeprom_chk_inst (.clk(clk), .rst(rst), .scl(scl), .sda_oe(sda_oe),
	.busy(busy), .standby(standby), .write_protect(write_protect),
	.high_voltage_level(high_voltage_level),
	.permanent_lock_flag(permanent_lock_flag),
	.reversible_lock_flag(reversible_lock_flag));
